// >>> logic/ccp_channel.sv
`timescale 1ns/10ps
// Notes on behaviour
// - compare 16-bit value against timer count continuously
// - mode code selects the match action
// - match flag set with the match action
// - clearing control zeroes compare output latch
// - code 1010 flags only, no pin
// - code 1011 resets timer, starts conversion
// - trigger at once, timer clears next tick
// - trigger never sets timer overflow flag
// - compare change before tick cancels reset
// - timer runs synchronised, never asynchronous
// - timer clocked at instruction rate
// - no match detection during sleep
// - controller clears direction bit before output
// - pwm on pin, up to ten bits
// - period, timer control, duty, control set pwm
// - cleared control releases the pin
// - setup order: driver off, period, mode, duty, timer
// - select timer, clear flag, set prescale first
// - wait for timer flag before enabling driver
// - duty split: eight high, two low bits
// - period end clears timer, sets pin, latches; a zero duty leaves the pin low
// - pin clears when time base equals duty
module ccp_channel (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    output logic pin_level_o,
    output logic pin_drive_o,
    ccp_link_if.chan link
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] ctrl_reg; // channel_control
    logic [7:0] cmpl_reg; // compare_value_low / duty high bits
    logic [7:0] cmph_reg; // compare_value_high / buffered duty
    logic [7:0] period_reg; // pwm_period_value
    logic [2:0] tctl_reg; // pwm_timer_run and pwm_timer_prescale
    logic pflag_reg; // pwm_timer_flag
    logic [7:0] rdata_reg;
    logic cmp_out_reg; // compare output latch
    logic matched_reg; // action already taken for this count
    logic flag_reg; // channel_match_flag
    logic trig_reg;
    logic clr_req_reg;
    logic [7:0] tmr8_reg; // pwm timer
    logic [5:0] pre_reg; // prescale and quarter-cycle count
    logic [1:0] dlat_reg; // latched duty low bits
    logic pwm_out_reg;
    logic pin_level_reg, pin_drive_reg;
    logic [3:0] mode; // channel_mode_code
    logic is_pwm, is_cmp, owns_pin, cmp_eq, fire;
    logic step, period_end, wr_ctrl;
    logic [5:0] ps_last;
    logic [1:0] base_low;
    logic [9:0] duty_live;
    assign mode = ctrl_reg[3:0];
    assign is_pwm = (mode[3:2] == 2'b11);
    assign is_cmp = (mode == ccp_pkg::MODE_TOGGLE) || (mode[3:2] == 2'b10);
    // software-interrupt and event modes leave the pin alone
    assign owns_pin = is_pwm || (mode == ccp_pkg::MODE_TOGGLE) ||
        (mode == ccp_pkg::MODE_SET) || (mode == ccp_pkg::MODE_CLEAR);
    assign wr_ctrl = link.reg_wr && (link.reg_addr == ccp_pkg::IDX_CONTROL);

    // ****************************************************************
    // compare detection
    // ****************************************************************
    // equality moves on ticks and register writes; a halted core clock stops it all
    assign cmp_eq = (link.tmr_count == {cmph_reg, cmpl_reg});
    // one action per equal count, not one per core cycle
    assign fire = is_cmp && cmp_eq && !matched_reg;
    // re-arm once the count or the compare value moves away
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            matched_reg <= 1'b0;
        end else begin
            matched_reg <= is_cmp && cmp_eq;
        end
    end
    // control register, with duty low bits in 5:4
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= ccp_pkg::RESET_BYTE;
        end else if (wr_ctrl) begin
            ctrl_reg <= link.reg_wdata;
        end
    end
    // low compare byte, also the eight duty high bits
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmpl_reg <= ccp_pkg::RESET_BYTE;
        end else if (link.reg_wr && link.reg_addr == ccp_pkg::IDX_CMP_LOW) begin
            cmpl_reg <= link.reg_wdata;
        end
    end
    // high compare byte; read-only buffer while pwm runs
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmph_reg <= ccp_pkg::RESET_BYTE;
        end else if (is_pwm) begin
            if (period_end) begin
                cmph_reg <= cmpl_reg;
            end
        end else if (link.reg_wr && link.reg_addr == ccp_pkg::IDX_CMP_HIGH) begin
            cmph_reg <= link.reg_wdata;
        end
    end
    // period and timer control
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            period_reg <= ccp_pkg::RESET_BYTE;
            tctl_reg <= 3'h0;
        end else if (link.reg_wr) begin
            if (link.reg_addr == ccp_pkg::IDX_PERIOD) begin
                period_reg <= link.reg_wdata;
            end
            if (link.reg_addr == ccp_pkg::IDX_TMR_CTL) begin
                tctl_reg <= link.reg_wdata[2:0];
            end
        end
    end

    // ****************************************************************
    // compare actions
    // ****************************************************************
    // output latch; an all-zero control write forces it low
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmp_out_reg <= 1'b0;
        end else if (wr_ctrl && link.reg_wdata == ccp_pkg::RESET_BYTE) begin
            cmp_out_reg <= 1'b0;
        end else if (fire) begin
            unique case (mode)
                ccp_pkg::MODE_TOGGLE: cmp_out_reg <= !cmp_out_reg;
                ccp_pkg::MODE_SET: cmp_out_reg <= 1'b1;
                ccp_pkg::MODE_CLEAR: cmp_out_reg <= 1'b0;
                default: cmp_out_reg <= cmp_out_reg; // flag or event only
            endcase
        end
    end
    // match flag: a new match wins over a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            flag_reg <= 1'b0;
        end else if (fire) begin
            flag_reg <= 1'b1;
        end else if (link.flag_clr) begin
            flag_reg <= 1'b0;
        end
    end
    // special event: trigger now, ask for a clear at the next tick
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            trig_reg <= 1'b0;
            clr_req_reg <= 1'b0;
        end else begin
            trig_reg <= fire && mode == ccp_pkg::MODE_EVENT;
            if (fire && mode == ccp_pkg::MODE_EVENT) begin
                clr_req_reg <= 1'b1;
            end else if (link.tmr_tick) begin
                clr_req_reg <= 1'b0;
            end else if (!cmp_eq || mode != ccp_pkg::MODE_EVENT) begin
                // compare moved away before the timer edge
                clr_req_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // pwm time base: 8-bit timer over a 2-bit sub-count
    // ****************************************************************
    always_comb begin
        unique case (tctl_reg[2:1])
            2'h0: begin
                ps_last = ccp_pkg::PS1_LAST;
                base_low = pre_reg[1:0];
            end
            2'h1: begin
                ps_last = ccp_pkg::PS4_LAST;
                base_low = pre_reg[3:2];
            end
            default: begin
                ps_last = ccp_pkg::PS16_LAST;
                base_low = pre_reg[5:4];
            end
        endcase
    end
    assign step = tctl_reg[ccp_pkg::TCTL_RUN] && (pre_reg == ps_last);
    assign period_end = step && (tmr8_reg == period_reg);
    assign duty_live = {cmpl_reg, ctrl_reg[ccp_pkg::DUTY_LSB +: 2]};
    // timer and prescaler; cleared on the step after period match
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pre_reg <= 6'h00;
            tmr8_reg <= ccp_pkg::RESET_BYTE;
        end else if (tctl_reg[ccp_pkg::TCTL_RUN]) begin
            pre_reg <= step ? 6'h00 : pre_reg + 6'h01;
            if (period_end) begin
                tmr8_reg <= ccp_pkg::RESET_BYTE;
            end else if (step) begin
                tmr8_reg <= tmr8_reg + 8'h01;
            end
        end
    end
    // timer flag: period end wins over a software clear
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pflag_reg <= 1'b0;
        end else if (period_end) begin
            pflag_reg <= 1'b1;
        end else if (link.reg_wr && link.reg_addr == ccp_pkg::IDX_TMR_CTL &&
                     !link.reg_wdata[ccp_pkg::TCTL_FLAG]) begin
            pflag_reg <= 1'b0;
        end
    end
    // duty low-bit latch, the second half of the double buffer
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            dlat_reg <= 2'h0;
        end else if (is_pwm && period_end) begin
            dlat_reg <= ctrl_reg[ccp_pkg::DUTY_LSB +: 2];
        end
    end
    // pwm waveform; a duty beyond the period keeps the pin high
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pwm_out_reg <= 1'b0;
        end else if (!is_pwm) begin
            pwm_out_reg <= 1'b0;
        end else if (period_end) begin
            pwm_out_reg <= (duty_live != 10'h000);
        end else if ({tmr8_reg, base_low} == {cmph_reg, dlat_reg}) begin
            pwm_out_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // pin and read-back
    // ****************************************************************
    // driver is on only while the mode owns the pin and it is an output
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pin_level_reg <= 1'b0;
            pin_drive_reg <= 1'b0;
        end else begin
            pin_level_reg <= is_pwm ? pwm_out_reg : cmp_out_reg;
            pin_drive_reg <= owns_pin && !link.pin_dir_input;
        end
    end
    // registered read mux, one cycle behind the index
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= ccp_pkg::RESET_BYTE;
        end else begin
            unique case (link.reg_addr)
                ccp_pkg::IDX_CONTROL: rdata_reg <= ctrl_reg;
                ccp_pkg::IDX_CMP_LOW: rdata_reg <= cmpl_reg;
                ccp_pkg::IDX_CMP_HIGH: rdata_reg <= cmph_reg;
                ccp_pkg::IDX_PERIOD: rdata_reg <= period_reg;
                ccp_pkg::IDX_TMR_CTL: rdata_reg <= {pflag_reg, 4'h0, tctl_reg};
                ccp_pkg::IDX_TMR_CNT: rdata_reg <= tmr8_reg;
                default: rdata_reg <= ccp_pkg::RESET_BYTE;
            endcase
        end
    end
    assign pin_level_o = pin_level_reg;
    assign pin_drive_o = pin_drive_reg;
    assign link.reg_rdata = rdata_reg;
    assign link.tmr_clear_req = clr_req_reg;
    assign link.event_trig = trig_reg;
    assign link.match_flag = flag_reg;
endmodule

// >>> logic/ccp_controller.sv
`timescale 1ns/10ps
// ****************************************************************
// controlling party: apb slave, 16-bit timer, converter start
// ****************************************************************
module ccp_controller (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic adc_start_o,
    ccp_link_if.ctrl link
);
    logic wait_reg; // second access cycle marker
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic [2:0] addr_reg; // channel register index
    logic [7:0] wdata_reg;
    logic wr_reg; // channel write strobe
    logic [7:0] cfg_reg; // run, adc enable, pin direction, select
    logic ovf_reg; // timer_overflow_flag
    logic [15:0] t1_reg; // timer count pair
    logic [1:0] div_reg; // instruction clock divider
    logic tick_reg;
    logic clr_reg; // match flag clear pulse
    logic adc_reg;
    logic [7:0] adc_cnt_reg; // conversions started
    logic done;
    logic chan_range;
    logic [31:0] rd_mux;

    // completion edge: the master sees pready high here
    assign done = psel_i & penable_i & pready_reg;
    assign chan_range = (paddr_i[7:5] == 3'h0);

    // read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (chan_range) begin
            rd_mux = {24'h00_0000, link.reg_rdata};
        end else begin
            unique case (paddr_i)
                ccp_pkg::OFS_CONFIG: rd_mux = {24'h00_0000, cfg_reg};
                ccp_pkg::OFS_STATUS: rd_mux = {30'h0000_0000, ovf_reg,
                    link.match_flag};
                ccp_pkg::OFS_T1_COUNT: rd_mux = {16'h0000, t1_reg};
                ccp_pkg::OFS_ADC_COUNT: rd_mux = {24'h00_0000, adc_cnt_reg};
                default: rd_mux = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // ****************************************************************
    // apb handshake: two wait cycles so channel read data settles
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wait_reg <= 1'b0;
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            addr_reg <= 3'h0;
            wdata_reg <= ccp_pkg::RESET_BYTE;
            wr_reg <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (psel_i && !penable_i) begin
                // setup: index goes out so the channel can answer
                addr_reg <= paddr_i[4:2];
                wdata_reg <= pwdata_i[7:0];
                wait_reg <= 1'b0;
            end else if (done) begin
                pready_reg <= 1'b0;
            end else if (psel_i && penable_i) begin
                wait_reg <= 1'b1;
                if (wait_reg) begin
                    pready_reg <= 1'b1;
                    prdata_reg <= rd_mux;
                    // lands in the channel on the completion edge
                    wr_reg <= pwrite_i & chan_range;
                end
            end
        end
    end

    // own configuration register
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cfg_reg <= ccp_pkg::CONFIG_RESET; // pin starts as input
        end else if (done && pwrite_i && paddr_i == ccp_pkg::OFS_CONFIG) begin
            cfg_reg <= pwdata_i[7:0];
        end
    end

    // divider for the instruction clock tick
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            div_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            tick_reg <= cfg_reg[ccp_pkg::CFG_T1_RUN] &&
                (div_reg == ccp_pkg::TICK_LAST);
        end
    end

    // ****************************************************************
    // 16-bit timer with overflow flag
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            t1_reg <= ccp_pkg::RESET_WORD;
        end else if (done && pwrite_i && paddr_i == ccp_pkg::OFS_T1_COUNT) begin
            t1_reg <= pwdata_i[15:0];
        end else if (tick_reg) begin
            // a pending trigger clears on this timer edge
            t1_reg <= link.tmr_clear_req ? ccp_pkg::RESET_WORD
                : t1_reg + 16'h0001;
        end
    end

    // overflow flag: only a wrap sets it, never the trigger clear
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ovf_reg <= 1'b0;
        end else if (tick_reg && !link.tmr_clear_req &&
                     t1_reg == 16'hFFFF) begin
            ovf_reg <= 1'b1;
        end else if (done && pwrite_i && paddr_i == ccp_pkg::OFS_STATUS &&
                     pwdata_i[ccp_pkg::ST_T1_OVF]) begin
            ovf_reg <= 1'b0;
        end
    end

    // match flag clear pulse and converter start
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            clr_reg <= 1'b0;
            adc_reg <= 1'b0;
            adc_cnt_reg <= ccp_pkg::RESET_BYTE;
        end else begin
            clr_reg <= done && pwrite_i && paddr_i == ccp_pkg::OFS_STATUS &&
                pwdata_i[ccp_pkg::ST_MATCH];
            adc_reg <= link.event_trig & cfg_reg[ccp_pkg::CFG_ADC_EN];
            if (link.event_trig && cfg_reg[ccp_pkg::CFG_ADC_EN]) begin
                adc_cnt_reg <= adc_cnt_reg + 8'h01;
            end
        end
    end

    // outputs
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = 1'b0;
    assign adc_start_o = adc_reg;
    assign link.reg_wr = wr_reg;
    assign link.reg_addr = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign link.tmr_count = t1_reg;
    assign link.tmr_tick = tick_reg;
    assign link.flag_clr = clr_reg;
    assign link.pin_dir_input = cfg_reg[ccp_pkg::CFG_PIN_DIR];
endmodule

// >>> logic/ccp_link_if.sv
`timescale 1ns/10ps
// ****************************************************************
// link between the channel and its controlling party
// ****************************************************************
interface ccp_link_if;
    logic reg_wr; // one-cycle register write strobe
    logic [2:0] reg_addr; // register index
    logic [7:0] reg_wdata; // write data
    logic [7:0] reg_rdata; // registered read data of reg_addr
    logic [15:0] tmr_count; // 16-bit timer count pair
    logic tmr_tick; // timer steps at the coming edge
    logic tmr_clear_req; // clear timer at next tick
    logic event_trig; // special event trigger pulse
    logic flag_clr; // clear channel_match_flag pulse
    logic match_flag; // channel_match_flag level
    logic pin_dir_input; // pin_direction_bit, high = input

    // the channel end
    modport chan (
        input reg_wr, reg_addr, reg_wdata, tmr_count, tmr_tick,
        input flag_clr, pin_dir_input,
        output reg_rdata, tmr_clear_req, event_trig, match_flag
    );
    // the controlling end
    modport ctrl (
        output reg_wr, reg_addr, reg_wdata, tmr_count, tmr_tick,
        output flag_clr, pin_dir_input,
        input reg_rdata, tmr_clear_req, event_trig, match_flag
    );
endinterface

// >>> logic/ccp_pkg.sv
// ****************************************************************
// shared constants for the channel and its controller
// ****************************************************************
package ccp_pkg;
    // channel register indices on the link
    localparam logic [2:0] IDX_CONTROL = 3'h0;
    localparam logic [2:0] IDX_CMP_LOW = 3'h1;
    localparam logic [2:0] IDX_CMP_HIGH = 3'h2;
    localparam logic [2:0] IDX_PERIOD = 3'h3;
    localparam logic [2:0] IDX_TMR_CTL = 3'h4;
    localparam logic [2:0] IDX_TMR_CNT = 3'h5;
    // channel_mode_code values
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_SWINT = 4'hA;
    localparam logic [3:0] MODE_EVENT = 4'hB;
    // field positions inside channel_control / pwm_timer_control
    localparam int DUTY_LSB = 4;
    localparam int TCTL_RUN = 0;
    localparam int TCTL_PS_LSB = 1;
    localparam int TCTL_FLAG = 7;
    // prescale terminal counts for 1:1, 1:4 and 1:16
    localparam logic [5:0] PS1_LAST = 6'h03;
    localparam logic [5:0] PS4_LAST = 6'h0F;
    localparam logic [5:0] PS16_LAST = 6'h3F;
    // controller apb byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_T1_COUNT = 8'h28;
    localparam logic [7:0] OFS_ADC_COUNT = 8'h2C;
    // config bits
    localparam int CFG_T1_RUN = 0;
    localparam int CFG_ADC_EN = 1;
    localparam int CFG_PIN_DIR = 2;
    localparam int CFG_TSEL_LSB = 3;
    localparam logic [7:0] CONFIG_RESET = 8'h04;
    // status bits
    localparam int ST_MATCH = 0;
    localparam int ST_T1_OVF = 1;
    // timer tick divider: instruction clock is core clock / 4
    localparam logic [1:0] TICK_LAST = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// >>> testbench/ccp_compare_and_pwm_setup_tb.sv
`timescale 1ns/10ps
// ****************************************
// both ends joined, driven over apb
// ****************************************
module ccp_compare_and_pwm_setup_tb;
    logic core_clk_i = 1'b0; // 125 MHz
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, m;
    logic pready, pslverr, adc_start, pin_level, pin_drive;
    logic [31:0] exp_q[$], msk_q[$]; // notes of expected read data
    int fails = 0;
    int n_checks = 0;
    int n_adc = 0;
    logic [15:0] v;
    // modes chosen so every pin action changes the latch; swint leaves it as it is
    logic [3:0] md[4] = '{ccp_pkg::MODE_SET, ccp_pkg::MODE_CLEAR,
        ccp_pkg::MODE_TOGGLE, ccp_pkg::MODE_SWINT};
    logic lv[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic dv[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    always #4 core_clk_i = ~core_clk_i;
    ccp_link_if link ();
    ccp_controller ccp_controller_inst (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .adc_start_o(adc_start), .link(link));
    ccp_channel ccp_channel_inst (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .pin_level_o(pin_level),
        .pin_drive_o(pin_drive), .link(link));
    ccp_link_chk ccp_link_chk_inst (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .reg_wr(link.reg_wr),
        .tmr_count(link.tmr_count), .tmr_tick(link.tmr_tick),
        .tmr_clear_req(link.tmr_clear_req), .event_trig(link.event_trig),
        .flag_clr(link.flag_clr), .match_flag(link.match_flag));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one transfer; for reads d is the expected data under mask k
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] k);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(k);
        end
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_i);
    endtask
    // read data is taken only at the completing edge
    always @(posedge core_clk_i) begin
        if (adc_start === 1'b1) n_adc++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            m = msk_q.pop_front();
            check(prdata & m, exp_q.pop_front() & m);
            check(pslverr, 1'b0);
        end
    end
    initial begin
        repeat (5000) @(posedge core_clk_i);
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hF59A979D));
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        apb(1'b0, ccp_pkg::OFS_CONFIG, 32'h04, 32'hFF);
        apb(1'b0, 8'h3C, 32'h0, 32'hFFFFFFFF);
        // each mode: stopped timer parked away from the new value first
        for (int i = 0; i < 4; i++) begin
            v = 16'h0100 + 16'($urandom % 32'hE000);
            apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h0, 32'h0);
            apb(1'b1, ccp_pkg::OFS_T1_COUNT, 32'h0, 32'h0);
            apb(1'b1, 8'h00, {28'h0, md[i]}, 32'h0);
            apb(1'b1, 8'h04, {24'h0, v[7:0]}, 32'h0);
            apb(1'b1, 8'h08, {24'h0, v[15:8]}, 32'h0);
            apb(1'b1, ccp_pkg::OFS_T1_COUNT, {16'h0, v - 16'h2}, 32'h0);
            apb(1'b1, ccp_pkg::OFS_STATUS, 32'h3, 32'h0);
            apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h1, 32'h0);
            repeat (24) @(posedge core_clk_i);
            apb(1'b0, ccp_pkg::OFS_STATUS, 32'h1, 32'h3);
            check(pin_drive, dv[i]);
            check(pin_level, lv[i]);
        end
        apb(1'b1, 8'h00, 32'h0, 32'h0);
        repeat (2) @(posedge core_clk_i);
        check(pin_level, 1'b0);
        check(pin_drive, 1'b0);
        // special event with the converter enabled
        v = v & 16'hFFF0;
        apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h2, 32'h0);
        apb(1'b1, ccp_pkg::OFS_T1_COUNT, 32'h0, 32'h0);
        apb(1'b1, 8'h00, {28'h0, ccp_pkg::MODE_EVENT}, 32'h0);
        apb(1'b1, 8'h04, {24'h0, v[7:0]}, 32'h0);
        apb(1'b1, 8'h08, {24'h0, v[15:8]}, 32'h0);
        apb(1'b1, ccp_pkg::OFS_T1_COUNT, {16'h0, v - 16'h2}, 32'h0);
        apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h3, 32'h0);
        repeat (24) @(posedge core_clk_i);
        apb(1'b0, ccp_pkg::OFS_ADC_COUNT, 32'h1, 32'hFFFF);
        apb(1'b0, ccp_pkg::OFS_STATUS, 32'h1, 32'h3);
        check(pin_drive, 1'b0);
        check(n_adc, 32'h1);
        // trigger on a stopped timer, then move the compare value away
        apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h2, 32'h0);
        apb(1'b1, ccp_pkg::OFS_T1_COUNT, {16'h0, v}, 32'h0);
        apb(1'b1, 8'h04, {24'h0, v[7:0] ^ 8'h80}, 32'h0);
        apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h3, 32'h0);
        apb(1'b1, ccp_pkg::OFS_CONFIG, 32'h2, 32'h0);
        apb(1'b0, ccp_pkg::OFS_T1_COUNT, {16'h0, v}, 32'hFFF0);
        // pwm in setup order, driver off until the flag
        apb(1'b1, 8'h20, 32'h04, 32'h0);
        apb(1'b1, 8'h0C, 32'h03, 32'h0);
        apb(1'b1, 8'h00, 32'h0C, 32'h0);
        apb(1'b1, 8'h04, 32'h02, 32'h0);
        apb(1'b1, 8'h20, 32'h0C, 32'h0);
        apb(1'b1, 8'h10, 32'h01, 32'h0);
        repeat (40) @(posedge core_clk_i);
        apb(1'b0, 8'h10, 32'h81, 32'hFF);
        check(pin_drive, 1'b0);
        apb(1'b1, 8'h20, 32'h08, 32'h0);
        apb(1'b0, 8'h08, 32'h02, 32'hFF);
        check(pin_drive, 1'b1);
        apb(1'b1, 8'h00, 32'h0, 32'h0);
        @(posedge core_clk_i);
        check(pin_drive, 1'b0);
        give_verdict();
    end
endmodule

// >>> testbench/ccp_link_chk.sv
`timescale 1ns/10ps
// ****************************************
// link checks between channel and controller
// ****************************************
module ccp_link_chk (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr,
    input wire logic [15:0] tmr_count,
    input wire logic tmr_tick,
    input wire logic tmr_clear_req,
    input wire logic event_trig,
    input wire logic flag_clr,
    input wire logic match_flag
);
    // one domain, so one default clock and reset
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // a stalled count must not fire again
    AST_TRIG_ONCE: assert property (event_trig |=> !event_trig [*2])
        else $error("trigger repeated");
    AST_TRIG_FLAG: assert property (event_trig |-> match_flag)
        else $error("flag missing with trigger");
    AST_TRIG_REQ: assert property (event_trig |-> tmr_clear_req)
        else $error("timer reset not requested");
    AST_REQ_CAUSE: assert property ($rose(tmr_clear_req) |-> event_trig)
        else $error("reset request without trigger");
    // the clear waits for the timer's own step
    AST_TICK_CLEAR: assert property (tmr_clear_req && tmr_tick
        |=> tmr_count == 16'h0000)
        else $error("timer not cleared at tick");
    AST_REQ_DONE: assert property (tmr_clear_req && tmr_tick
        |=> !tmr_clear_req)
        else $error("request outlived tick");
    // only a register write may cancel a pending reset
    AST_REQ_HOLD: assert property (tmr_clear_req && !tmr_tick && !reg_wr
        && !$past(reg_wr) |=> tmr_clear_req)
        else $error("request dropped early");
    AST_FLAG_HOLD: assert property (match_flag && !flag_clr
        |=> match_flag)
        else $error("flag lost without clear");
endmodule
